/* hw/indirect_window_pkg.sv */
// Package: register numbers, widths, reset values and timing for the indirect window
package indirect_window_pkg;
   localparam int unsigned            DATA_W            = 32;
   localparam int unsigned            NUM_W             = 14;
   localparam logic [NUM_W-1:0]       REG_INDEX         = 14'h0007;
   localparam logic [NUM_W-1:0]       REG_VALUE         = 14'h0008;
   localparam logic [NUM_W-1:0]       REG_DIRECT_LAST   = 14'h0006;
   localparam logic [NUM_W-1:0]       REG_DIRECT_NINE   = 14'h0009;
   localparam logic [NUM_W-1:0]       REG_FILTER_ENABLE = 14'h0106;
   localparam logic [NUM_W-1:0]       REG_FILTER_INTVL  = 14'h0107;
   localparam logic [NUM_W-1:0]       REG_NUM_MAX       = 14'h270F;
   localparam logic [DATA_W-1:0]      INDEX_RESET       = 32'h0000_0009;
   localparam logic [DATA_W-1:0]      FILTER_INTVL_RST  = 32'h0000_0010;
   localparam logic [DATA_W-1:0]      FILTER_EN_RESET   = 32'h0000_0000;
   localparam int unsigned            NUM_INPUTS        = 16;
   localparam int unsigned            CLOCK_MHZ         = 100;
   localparam int unsigned            MS_CYCLES         = CLOCK_MHZ * 1000;
   localparam int unsigned            GEN_REGS          = 8;
endpackage : indirect_window_pkg

/* hw/indirect_register_window.sv */
// Module: register window with direct numbers and an index/value pair for indirect access
`timescale 1ns/1ns

//////////////////////////////////////////////////////////////////////////////////////////////////
module indirect_register_window
   import indirect_window_pkg::*;
#(
   parameter int unsigned N_IN = NUM_INPUTS
) (
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   input  wire logic [NUM_W-1:0]       reg_num,
   input  wire logic [DATA_W-1:0]      reg_wdata,
   output logic      [DATA_W-1:0]      reg_rdata,
   output logic                        reg_rvalid,
   output logic                        reg_err,
   input  wire logic [N_IN-1:0]        inputs_raw,
   output logic      [N_IN-1:0]        inputs_filtered,
   output logic      [DATA_W-1:0]      filter_enable_reg,
   output logic      [DATA_W-1:0]      filter_interval_reg
);
   import indirect_window_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Target decode shared by direct and indirect paths
   // Numbers 7 and 8 are the window itself; 8 never decodes to a target, so a
   // window aimed at itself is refused instead of looping back on the value port
   typedef enum {T_NONE, T_GEN, T_INDEX, T_FEN, T_FINT} target_e;

   // General register numbers: the low direct block plus number 9
   function automatic logic is_general(input logic [NUM_W-1:0] n);
      return n <= REG_DIRECT_LAST || n == REG_DIRECT_NINE;
   endfunction : is_general

   // Target of a register number; anything unlisted answers as nothing
   function automatic target_e decode(input logic [NUM_W-1:0] n);
      target_e t;
      t = T_NONE;
      if (is_general(n)) begin
         t = T_GEN;
      end else if (n == REG_INDEX) begin
         t = T_INDEX;
      end else if (n == REG_FILTER_ENABLE) begin
         t = T_FEN;
      end else if (n == REG_FILTER_INTVL) begin
         t = T_FINT;
      end
      return t;
   endfunction : decode

   // Slot of a general register: 0..6 map to themselves, 9 to slot 7
   // Eight words cover the whole direct block, so no slot is wasted
   function automatic logic [2:0] slot(input logic [NUM_W-1:0] n);
      return (n == REG_DIRECT_NINE) ? 3'h7 : n[2:0];
   endfunction : slot

   // Storage behind the register numbers
   logic [DATA_W-1:0]  index_q;
   logic [DATA_W-1:0]  gen_q [GEN_REGS];

   // Steering of the access in flight
   logic [NUM_W-1:0]   index_num;
   logic               direct_ok;
   logic               via_value;
   logic [NUM_W-1:0]   eff_num;
   target_e            eff_t;
   logic               acc_ok;

   // Per-target write strobes and the shared filter limit
   logic               wr_index;
   logic               wr_gen;
   logic               wr_fen;
   logic               wr_fint;
   logic [DATA_W+16:0] filt_limit;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Access steering
   // direct number check
   assign direct_ok = is_general(reg_num) || reg_num == REG_INDEX || reg_num == REG_VALUE;
   // The value register redirects the access to the indexed number
   assign via_value = reg_num == REG_VALUE;
   // Index cut to the number width; the range check keeps its upper bits zero
   assign index_num = index_q[NUM_W-1:0];
   assign eff_num   = via_value ? index_num : reg_num;
   // One decode serves both paths; direct and window answers differ only at 8 and where direct_ok refuses a number
   assign eff_t     = decode(eff_num);
   // Unknown targets through the window read zero and drop writes, flagged as error
   assign acc_ok    = direct_ok && (!via_value || eff_t != T_NONE);

   // Write strobes per target; a refused access reaches none of them
   assign wr_index  = reg_wr && acc_ok && eff_t == T_INDEX;
   assign wr_gen    = reg_wr && acc_ok && eff_t == T_GEN;
   assign wr_fen    = reg_wr && acc_ok && eff_t == T_FEN;
   assign wr_fint   = reg_wr && acc_ok && eff_t == T_FINT;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Index register
   // Shared by every host source; the pair carries no owner, so two sources
   // interleaving index and value accesses would hit each other's targets
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         index_q <= INDEX_RESET;
      end else if (wr_index) begin
         // out of range ignored, keeps old target rather than wrapping
         if (reg_wdata <= DATA_W'(REG_NUM_MAX)) begin
            index_q <= reg_wdata;
         end
      end
   end

   // General module registers, directly or indirectly reachable
   // Plain storage with no side effects on read
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < GEN_REGS; i++) begin
            gen_q[i] <= '0;
         end
      end else if (wr_gen) begin
         gen_q[slot(eff_num)] <= reg_wdata;
      end
   end

   // Filter enable and interval, only reachable through the window
   // A direct access to 262 or 263 is refused, so only the window changes them
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         // Filters start off, the interval at 16 ms
         filter_enable_reg   <= FILTER_EN_RESET;
         filter_interval_reg <= FILTER_INTVL_RST;
      end else begin
         if (wr_fen) begin
            filter_enable_reg <= reg_wdata;
         end
         if (wr_fint) begin
            filter_interval_reg <= reg_wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Read answer, one cycle after the strobe
   // Registered, so a host never samples data in the cycle of its own strobe
   // Refused reads answer zero rather than a stale word, with the error pulse
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata  <= '0;
         reg_rvalid <= 1'b0;
         reg_err    <= 1'b0;
      end else begin
         // Every read is answered, refused or not, so the host can count answers
         reg_rvalid <= reg_rd;
         // Error pulse for refused reads and writes alike
         reg_err    <= (reg_rd || reg_wr) && !acc_ok;
         if (reg_rd) begin
            case (eff_t)
               T_GEN:   reg_rdata <= gen_q[slot(eff_num)];
               T_INDEX: reg_rdata <= index_q;
               T_FEN:   reg_rdata <= filter_enable_reg;
               T_FINT:  reg_rdata <= filter_interval_reg;
               default: reg_rdata <= '0;
            endcase
            // A refused read overrides whatever the decode picked
            if (!acc_ok) begin
               reg_rdata <= '0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Digital filter per input: output follows only after input is stable for the interval
   // Interval in cycles, shared by all inputs and wide enough for the largest interval word
   // Limitation: an interval of zero lets a filtered input follow after a single cycle
   assign filt_limit = (DATA_W+17)'(filter_interval_reg) * (DATA_W+17)'(MS_CYCLES);

   // Each input counts on its own; a bounce back restarts its count
   genvar g;
   for (g = 0; g < N_IN; g++) begin : g_filt
      // Counter as wide as the limit, so it never wraps before the interval ends
      logic [DATA_W+16:0] cnt_q;
      always_ff @(posedge clock or negedge rst_n) begin
         if (!rst_n) begin
            cnt_q              <= '0;
            inputs_filtered[g] <= 1'b0;
         end else if (!filter_enable_reg[g]) begin
            cnt_q              <= '0;
            inputs_filtered[g] <= inputs_raw[g];
         // Input back at the held level: the bounce is over
         end else if (inputs_raw[g] == inputs_filtered[g]) begin
            cnt_q <= '0;
         end else if (cnt_q + 1'b1 >= filt_limit) begin
            cnt_q              <= '0;
            inputs_filtered[g] <= inputs_raw[g];
         // Still differing: keep counting
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

endmodule : indirect_register_window

/* verification/window_asserts.sv */
// Checker: port-level assertions for the indirect register window
`timescale 1ns/1ns
module window_asserts
   import indirect_window_pkg::*;
(
   input wire logic              clock,
   input wire logic              rst_n,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [NUM_W-1:0]  reg_num,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic              reg_rvalid,
   input wire logic              reg_err,
   input wire logic [DATA_W-1:0] filter_enable_reg,
   input wire logic [DATA_W-1:0] filter_interval_reg
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Any access, read or write
   wire acc = reg_wr | reg_rd;
   far_err_a: assert property (acc && reg_num > REG_DIRECT_NINE |=> reg_err)
      else $error("far direct access not refused");
   far_zero_a: assert property (reg_rd && reg_num > REG_DIRECT_NINE |=> reg_rdata == '0)
      else $error("refused read not zero");
   near_ok_a: assert property (acc && reg_num <= REG_DIRECT_NINE &&
      reg_num != REG_VALUE |=> !reg_err) else $error("direct access refused");
   rd_answer_a: assert property (reg_rd |=> reg_rvalid || reg_err)
      else $error("read not answered");
   rd_quiet_a: assert property (!reg_rd |=> !reg_rvalid)
      else $error("answer without read");
   intvl_hold_a: assert property (!reg_wr |=> $stable(filter_interval_reg))
      else $error("interval changed without write");
   enable_hold_a: assert property (!reg_wr |=> $stable(filter_enable_reg))
      else $error("enable changed without write");
endmodule : window_asserts
bind indirect_register_window window_asserts chk (.clock(clock), .rst_n(rst_n),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_num(reg_num), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .reg_err(reg_err), .filter_enable_reg(filter_enable_reg),
   .filter_interval_reg(filter_interval_reg));

/* verification/host_model.sv */
// Partner: bus controller issuing single register accesses
`timescale 1ns/1ns
module host_model (
   input wire logic    clock,
   output logic        reg_wr,
   output logic        reg_rd,
   output logic [13:0] reg_num,
   output logic [31:0] reg_wdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_num = '0;
      reg_wdata = '0;
   end
   // one source, index then value
   // Strobe for one edge; released lines show inverted data so stale values never match
   task automatic acc(input logic w, input logic [13:0] n, input logic [31:0] d);
      @(posedge clock);
      reg_wr <= w;
      reg_rd <= ~w;
      reg_num <= n;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_num <= ~n;
      reg_wdata <= ~d;
   endtask : acc
endmodule : host_model

/* verification/tb_top.sv */
// Testbench: direct and indirect register access through the host model
`timescale 1ns/1ns
module tb_top;
   import indirect_window_pkg::*;
   logic              clock = 1'b0;
   logic              rst_n = 1'b0;
   logic [15:0]       inputs_raw = '0;
   logic [15:0]       filt;
   logic [31:0]       rdata, fen, fint, v;
   logic              rvalid, err;
   wire               reg_wr, reg_rd;
   wire  [13:0]       reg_num;
   wire  [31:0]       reg_wdata;
   logic [32:0]       exp_q[$];
   int                dn[8] = '{0, 1, 2, 3, 4, 5, 6, 9};
   int                err_total = 0;
   int                num_checks = 0;
   initial forever #5 clock = ~clock;
   host_model host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_num(reg_num),
      .reg_wdata(reg_wdata));
   indirect_register_window uut (.clock(clock), .rst_n(rst_n), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_num(reg_num), .reg_wdata(reg_wdata), .reg_rdata(rdata),
      .reg_rvalid(rvalid), .reg_err(err), .inputs_raw(inputs_raw), .inputs_filtered(filt),
      .filter_enable_reg(fen), .filter_interval_reg(fint));
   task automatic check(input logic [32:0] seen, input logic [32:0] want);
      num_checks++;
      if (seen !== want) begin
         err_total++;
         $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check
   task automatic end_sim;
      $display("checks=%0d errors=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim
   // Reads note {err, data} first; the monitor pairs answers in order
   task automatic rd(input logic [13:0] n, input logic [32:0] want);
      exp_q.push_back(want);
      host.acc(1'b0, n, '0);
   endtask : rd
   // Any answer pulse after reset, unknown included, takes the oldest note
   always @(posedge clock) begin
      if (rst_n && (rvalid !== 1'b0 || err !== 1'b0)) begin
         check({err, rdata}, exp_q.size() ? exp_q.pop_front() : 33'h1_FFFF_FFFF);
      end
   end
   initial begin
      void'($urandom(32'h2182));
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      rd(REG_INDEX, 33'h9);
      check({1'b0, fint}, {1'b0, FILTER_INTVL_RST});
      // Each direct register both ways through the window
      foreach (dn[i]) begin
         v = $urandom();
         host.acc(1'b1, 14'(dn[i]), v);
         host.acc(1'b1, REG_INDEX, 32'(dn[i]));
         rd(REG_VALUE, {1'b0, v});
         v = $urandom();
         host.acc(1'b1, REG_VALUE, v);
         rd(14'(dn[i]), {1'b0, v});
      end
      host.acc(1'b1, REG_INDEX, 32'(REG_FILTER_INTVL));
      host.acc(1'b1, REG_VALUE, 32'h0);
      host.acc(1'b1, REG_INDEX, 32'(REG_FILTER_ENABLE));
      host.acc(1'b1, REG_VALUE, 32'h7);
      repeat (2) @(posedge clock);
      check({1'b0, fen}, 33'h7);
      check({1'b0, fint}, 33'h0);
      rd(REG_VALUE, 33'h7);
      rd(REG_VALUE, 33'h7);
      inputs_raw <= 16'($urandom());
      repeat (4) @(posedge clock);
      check({17'h0, filt}, {17'h0, inputs_raw});
      // Index beyond 9999 is dropped and the old target kept
      host.acc(1'b1, REG_INDEX, 32'h2710);
      rd(REG_INDEX, {1'b0, 32'(REG_FILTER_ENABLE)});
      rd(14'(10 + $urandom_range(9989)), 33'h1_0000_0000);
      // Window aimed at itself is refused; a direct write to 262 is dropped
      host.acc(1'b1, REG_INDEX, 32'(REG_VALUE));
      rd(REG_VALUE, 33'h1_0000_0000);
      exp_q.push_back(33'h1_0000_0000);
      host.acc(1'b1, REG_FILTER_ENABLE, $urandom());
      repeat (2) @(posedge clock);
      check({1'b0, fen}, 33'h7);
      // Long interval: enabled inputs hold their level, the others follow at once
      host.acc(1'b1, REG_INDEX, 32'(REG_FILTER_INTVL));
      host.acc(1'b1, REG_VALUE, 32'h1);
      v = 32'(inputs_raw);
      inputs_raw <= ~inputs_raw;
      repeat (4) @(posedge clock);
      check({17'h0, filt}, {17'h0, ~v[15:3], v[2:0]});
      repeat (4) @(posedge clock);
      check(33'(exp_q.size()), 33'h0);
      end_sim();
   end
   initial begin
      #200000;
      err_total++;
      end_sim();
   end
endmodule : tb_top
